/* File: rtl/rbc_top.sv */
// Reset, boot-start and clock-ratio control for a multicore signal processor.
// Assumes straps stable while powered and all inputs synchronous to CLK.
//
// Overview of operation
// [R1] Board asserts chip reset only after clock, static inputs and straps are stable.
// [R2] Every later chip reset via the reset input returns all logic to reset.
// [R3] Soft reset bit in emulation control resets only the core, not I/O.
// [R4] Board ties reset-complete output to the memory power-on reset input.
// [R5] Four start options: EPROM load, host load, link load, no load.
// [R6] No-load start: line 0, 1, 2 pick 0x30000000, 0x38000000, 0x80000000.
// [R7] No-load start: line 3 picks internal address zero.
// [R8] Core leaves any reset idle, waiting for interrupt; some vectors enabled.
// [R9] Core clock is system clock times the strap-selected multiplier.
// [R10] Link transmit clock comes from core clock via programmable divisor.
// [R11] On-chip bus runs at half the core clock rate.
// [R12] External bus uses system clock, at most a quarter of core clock.
// [R13] Strap codes give multipliers 4,5,6,7,8,10,12; code 111 reserved.
// [R14] Board holds ratio straps constant while powered.
// [R15] Reset-complete output signals once the internal sequence finishes.
// [R16] Chip reset is synchronised before release.
// [R17] Reserved strap code flagged invalid and never used as a multiplier.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
module rbc_top
  import rbc_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic [7:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  input  wire logic [2:0]        CLOCK_RATIO_STRAPS,
  input  wire logic [1:0]        BOOT_MODE_STRAPS,
  input  wire logic [3:0]        EXT_INTERRUPT_LINES_N,
  input  wire logic              BOOT_LOAD_DONE,
  output logic                   RESET_DONE_N,
  output logic                   CORE_RESET_N,
  output logic                   IO_RESET_N,
  output logic                   CORE_RUN,
  output logic      [31:0]       CORE_START_ADDR,
  output logic      [3:0]        CORE_IRQ_ENABLE,
  output logic      [3:0]        CORE_CLOCK_MULT,
  output logic                   RATIO_INVALID,
  output logic                   ONCHIP_BUS_CLOCK,
  output logic                   LINK_CLOCK_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Strap code to multiplier; reserved code yields zero
  function automatic logic [3:0] ratio_mult(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h0;
    case (code)
      3'h0:    m = 4'h4;
      3'h1:    m = 4'h5;
      3'h2:    m = 4'h6;
      3'h3:    m = 4'h7;
      3'h4:    m = 4'h8;
      3'h5:    m = 4'hA;
      3'h6:    m = 4'hC;
      default: m = 4'h0;
    endcase
    return m;
  endfunction : ratio_mult

  // Zero for the reserved code is deliberate: no real PLL can lock at a
  // multiplier of zero, so a board that leaves the straps at 111 is caught
  // at bring-up rather than running at some guessed ratio.
  // The invalid flag is kept beside it so software need not decode the table.

  ////////////////////////////////////////////////////////////////////////////
  // State
  //
  // All flip-flops of the block outside the two clock dividers live in one packed struct:
  //   sync1, sync2  two-stage release of the chip reset
  //   seq_cnt, done internal reset sequence and its completion flag
  //   strap, boot   strap values caught once per chip reset
  //   mult, inval   decoded clock multiplier and reserved-code flag
  //   soft_cnt      remaining cycles of a core-only reset
  //   state, run    core start state and its registered run flag
  //   addr          fetch start address handed to the core
  //   link_div      software divisor for the link transmit clock
  //   rdata         registered read data, valid one cycle only
  //   core_rst_n    core reset, chip or soft
  //   io_rst_n      I/O reset, chip reset only
  //   irq_en        interrupt enables set up by any reset

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic [CNT_W-1:0] seq_cnt;
    logic             done;
    logic [2:0]       strap;
    rbc_boot_t        boot;
    logic [3:0]       mult;
    logic             inval;
    logic [CNT_W-1:0] soft_cnt;
    rbc_core_t        state;
    logic             run;
    logic [31:0]      addr;
    logic [DIV_W-1:0] link_div;
    logic [31:0]      rdata;
    logic             core_rst_n;
    logic             io_rst_n;
    logic [3:0]       irq_en;
  } rbc_st_t;

  rbc_st_t    st_r;
  rbc_st_t    st_nxt;
  logic       link_clk;
  logic       bus_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [3:0]  irq;
    logic        soft_wr;
    logic        in_reset;
    irq      = ~EXT_INTERRUPT_LINES_N;
    soft_wr  = WR && (ADDR == EMU_CTL_OFS) && WDATA[EMU_SOFT_RST_BIT];
    in_reset = ~st_r.done;
    st_nxt   = st_r;

    // Two-stage release of the chip reset
    st_nxt.sync1 = 1'b1;                                        // [R16]
    st_nxt.sync2 = st_r.sync1;                                  // [R16]

    // Internal sequence after release; straps caught once, at release
    if (st_r.sync2 && !st_r.done)
    begin
      if (st_r.seq_cnt == '0)
      begin
        st_nxt.strap = CLOCK_RATIO_STRAPS;                      // [R9]
        st_nxt.boot  = rbc_boot_t'(BOOT_MODE_STRAPS);           // [R5]
      end
      if (st_r.seq_cnt == CNT_W'(RST_SEQ_CYC - 1))
        st_nxt.done = 1'b1;                                     // [R15]
      else
        st_nxt.seq_cnt = st_r.seq_cnt + CNT_W'(1);
    end

    // Multiplier only from a legal code
    st_nxt.inval = (st_r.strap == STRAP_RESERVED);              // [R17]
    st_nxt.mult  = ratio_mult(st_r.strap);                      // [R13] [R17]

    // Core-only reset leaves I/O running
    // A write during a running pulse restarts it, so the core always sees
    // the full pulse length after the last request.
    if (soft_wr && st_r.done)
      st_nxt.soft_cnt = CNT_W'(CORE_RST_CYC);                   // [R3]
    else if (st_r.soft_cnt != '0)
      st_nxt.soft_cnt = st_r.soft_cnt - CNT_W'(1);
    st_nxt.io_rst_n   = st_r.done;                              // [R2]
    st_nxt.core_rst_n = st_r.done && (st_nxt.soft_cnt == '0);   // [R3]

    // Core start control
    // Interrupt lines are taken as already synchronous; an asynchronous
    // source needs its own synchroniser in front of this block.
    case (st_r.state)
      CS_HELD:
      begin
        st_nxt.irq_en = IRQ_EN_RST;                             // [R8]
        st_nxt.addr   = '0;
        if (st_r.core_rst_n)
          st_nxt.state = CS_IDLE;                               // [R8]
      end
      CS_IDLE:
      begin
        if (st_r.boot == BOOT_NONE)
        begin
          // Lowest line wins when several are asserted together
          if (irq[0])
            st_nxt.addr = START_IRQ0;                           // [R6]
          else if (irq[1])
            st_nxt.addr = START_IRQ1;                           // [R6]
          else if (irq[2])
            st_nxt.addr = START_IRQ2;                           // [R6]
          else if (irq[3])
            st_nxt.addr = START_IRQ3;                           // [R7]
          if (irq != 4'h0)
            st_nxt.state = CS_RUN;
        end
        else if (BOOT_LOAD_DONE)
        begin
          st_nxt.addr  = START_LOADED;                          // [R5]
          st_nxt.state = CS_RUN;
        end
      end
      CS_RUN:
      begin
        st_nxt.state = CS_RUN;
      end
      default:
      begin
        st_nxt.state = CS_HELD;
      end
    endcase
    if (!st_nxt.core_rst_n)
      st_nxt.state = CS_HELD;                                   // [R8]

    // Run flag registered so the output needs no decoding after the flop
    st_nxt.run = (st_nxt.state == CS_RUN);

    // Register writes
    // Ignored until the sequence is done, so a write racing the reset
    // release cannot leave the divisor half set up.
    if (WR && (ADDR == LINK_DIV_OFS) && !in_reset)
      st_nxt.link_div = WDATA[DIV_W-1:0];                       // [R10]

    // Register reads, data valid the next cycle only
    st_nxt.rdata = 32'h0000_0000;
    if (RD)
    begin
      case (ADDR)
        LINK_DIV_OFS:
          st_nxt.rdata[DIV_W-1:0] = st_r.link_div;
        STATUS_OFS:
        begin
          st_nxt.rdata[ST_STRAP_LSB +: 3] = st_r.strap;
          st_nxt.rdata[ST_INVALID_BIT]    = st_r.inval;
          st_nxt.rdata[ST_MULT_LSB +: 4]  = st_r.mult;
          st_nxt.rdata[ST_STATE_LSB +: 2] = st_r.state;
          st_nxt.rdata[ST_BOOT_LSB +: 2]  = st_r.boot;
          st_nxt.rdata[ST_DONE_BIT]       = st_r.done;
        end
        START_ADDR_OFS:
          st_nxt.rdata = st_r.addr;
        default:
          st_nxt.rdata = 32'h0000_0000;  // Soft reset bit self-clears, reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; every chip reset clears it, but loads LINK_DIV_RST into link_div and IRQ_EN_RST into irq_en
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_r          <= '0;                                      // [R2]
      st_r.link_div <= LINK_DIV_RST;
      st_r.irq_en   <= IRQ_EN_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived clocks; CLK stands in for the core clock here
  // Both dividers sit in I/O reset, not core reset: a soft core reset must
  // not stop the on-chip bus or a link transfer in flight.
  // Limitation: outputs are divided from CLK, so true ratios to the core
  // clock hold only once a real PLL supplies the multiplied clock.
  rbc_clk_div #(
    .W       (DIV_W)
  ) u_bus_div (
    .clk     (CLK),
    .rst_n   (st_r.io_rst_n),
    .div     (DIV_W'(ONCHIP_BUS_DIV)),                          // [R11]
    .clk_out (bus_clk)
  );

  rbc_clk_div #(
    .W       (DIV_W)
  ) u_link_div (
    .clk     (CLK),
    .rst_n   (st_r.io_rst_n),
    .div     (st_r.link_div),                                   // [R10]
    .clk_out (link_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  // No output is decoded after the flops, so none can glitch while the
  // core or board samples it.
  assign RDATA            = st_r.rdata;
  assign RESET_DONE_N     = st_r.done;                          // [R15] high once complete
  assign CORE_RESET_N     = st_r.core_rst_n;
  assign IO_RESET_N       = st_r.io_rst_n;
  assign CORE_RUN         = st_r.run;
  assign CORE_START_ADDR  = st_r.addr;
  assign CORE_IRQ_ENABLE  = st_r.irq_en;
  assign CORE_CLOCK_MULT  = st_r.mult;                          // [R9] [R12] never below 4, except zero during chip reset and on code 111
  assign RATIO_INVALID    = st_r.inval;
  assign ONCHIP_BUS_CLOCK = bus_clk;
  assign LINK_CLOCK_OUT   = link_clk;

endmodule : rbc_top

/* File: rtl/rbc_pkg.sv */
// Shared constants for the reset, boot-start and clock-ratio block.
// Assumes a single system clock; all users import the whole package.
package rbc_pkg;

  // Clock and timing
  localparam int          SYS_CLK_PERIOD_NS = 50;
  localparam int          RST_SEQ_NS        = 1000;  // Internal reset sequence length
  localparam int          RST_SEQ_CYC       = (RST_SEQ_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int          CORE_RST_NS       = 200;   // Core-only reset pulse length
  localparam int          CORE_RST_CYC      = (CORE_RST_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int          CNT_W             = 8;

  // Register offsets (byte addresses)
  localparam logic [7:0]  EMU_CTL_OFS       = 8'h00;
  localparam logic [7:0]  LINK_DIV_OFS      = 8'h04;
  localparam logic [7:0]  STATUS_OFS        = 8'h08;
  localparam logic [7:0]  START_ADDR_OFS    = 8'h0C;

  // Field positions
  localparam int          EMU_SOFT_RST_BIT  = 0;
  localparam int          ST_STRAP_LSB      = 0;
  localparam int          ST_INVALID_BIT    = 3;
  localparam int          ST_MULT_LSB       = 4;
  localparam int          ST_STATE_LSB      = 8;
  localparam int          ST_BOOT_LSB       = 10;
  localparam int          ST_DONE_BIT       = 12;

  // Reset values, reserved strap code and fixed bus divisor
  localparam logic [7:0]  LINK_DIV_RST      = 8'h02;
  localparam logic [3:0]  IRQ_EN_RST        = 4'hF;
  localparam logic [2:0]  STRAP_RESERVED    = 3'h7;
  localparam int          ONCHIP_BUS_DIV    = 1;     // Toggle each cycle: half rate

  // No-load start addresses by line, then the start address after a load
  localparam logic [31:0] START_IRQ0        = 32'h3000_0000;
  localparam logic [31:0] START_IRQ1        = 32'h3800_0000;
  localparam logic [31:0] START_IRQ2        = 32'h8000_0000;
  localparam logic [31:0] START_IRQ3        = 32'h0000_0000;
  localparam logic [31:0] START_LOADED      = 32'h0000_0000;

  // Boot options
  typedef enum logic [1:0] {
    BOOT_EPROM  = 2'h0,
    BOOT_HOST   = 2'h1,
    BOOT_LINK   = 2'h2,
    BOOT_NONE   = 2'h3
  } rbc_boot_t;

  // Core state, Gray along held -> idle -> run
  typedef enum logic [1:0] {
    CS_HELD     = 2'h0,
    CS_IDLE     = 2'h1,
    CS_RUN      = 2'h3
  } rbc_core_t;

endpackage : rbc_pkg

/* File: rtl/rbc_clk_div.sv */
// Clock divider that toggles its output every div cycles of the clock.
// Assumes div is stable while counting; a divisor of zero acts as one.
`timescale 1ns/1ns
module rbc_clk_div
  import rbc_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] div,
  output logic              clk_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } rbc_div_st_t;

  rbc_div_st_t st_r;
  rbc_div_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Count up the half period, then toggle
  always_comb
  begin
    logic [W-1:0] lim;
    lim    = (div == '0) ? W'(1) : div;
    st_nxt = st_r;
    if (st_r.cnt >= lim - W'(1))
    begin
      st_nxt.cnt = '0;
      st_nxt.out = ~st_r.out;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  // Held low in reset so the divided clock starts in a known phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign clk_out = st_r.out;

endmodule : rbc_clk_div

/* File: tb/rbc_board.sv */
// Board-side model: chip reset source and clock-ratio straps.
// Assumes the bench runs the clock from time zero; one clock domain.
`timescale 1ns/1ns
module rbc_board
(
  input  wire logic       clk,
  input  wire logic       rst_req,
  input  wire logic [2:0] ratio_sel,
  input  wire logic       mem_por_n,
  output logic            chip_rst_n,
  output logic [2:0]      ratio_straps
);
  logic [2:0] hold_cnt;

  // Reset held low from power-up while clock and straps settle
  initial
  begin
    chip_rst_n   = 1'b0;
    ratio_straps = 3'h0;
    hold_cnt     = 3'h4;
  end

  // Straps move only under reset, standing in for a power cycle
  // Memory power-on reset wired straight from reset-complete
  always_ff @(posedge clk)
  begin
    if (rst_req)
      hold_cnt <= 3'h4;
    else if (hold_cnt != 3'h0)
      hold_cnt <= hold_cnt - 3'h1;
    chip_rst_n <= (hold_cnt == 3'h0) && !rst_req;
    if (!chip_rst_n)
      ratio_straps <= ratio_sel;
  end
endmodule : rbc_board

/* File: tb/rbc_checker.sv */
// Port-level checker for the reset, boot-start and clock-ratio block.
// Assumes straps and boot mode stay still while reset-complete is high.
`timescale 1ns/1ns
module rbc_checker
  import rbc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic [2:0]  CLOCK_RATIO_STRAPS,
  input wire logic [1:0]  BOOT_MODE_STRAPS,
  input wire logic [3:0]  EXT_INTERRUPT_LINES_N,
  input wire logic        RESET_DONE_N,
  input wire logic        CORE_RESET_N,
  input wire logic        IO_RESET_N,
  input wire logic        CORE_RUN,
  input wire logic [31:0] CORE_START_ADDR,
  input wire logic [3:0]  CORE_IRQ_ENABLE,
  input wire logic [3:0]  CORE_CLOCK_MULT,
  input wire logic        RATIO_INVALID,
  input wire logic        ONCHIP_BUS_CLOCK,
  input wire logic        LINK_CLOCK_OUT
);
  logic [3:0] mult_exp;
  logic       last_link;
  logic [8:0] link_hold;

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Lowest active line wins
  function automatic logic [31:0] pick(input logic [3:0] l);
    return !l[0] ? 32'h3000_0000 : !l[1] ? 32'h3800_0000 : !l[2] ? 32'h8000_0000 : 32'h0;
  endfunction : pick

  // Multiplier table, zero on the reserved code
  assign mult_exp = CLOCK_RATIO_STRAPS == 3'h7 ? 4'h0 : CLOCK_RATIO_STRAPS == 3'h6 ? 4'hC
                  : CLOCK_RATIO_STRAPS == 3'h5 ? 4'hA : {1'b0, CLOCK_RATIO_STRAPS} + 4'h4;

  // Cycles the link clock has held its level; a stuck divider grows it
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      last_link <= 1'b0;
      link_hold <= 9'h001;
    end
    else
    begin
      last_link <= LINK_CLOCK_OUT;
      link_hold <= (!IO_RESET_N || LINK_CLOCK_OUT != last_link) ? 9'h001 : link_hold + 9'h001;
    end
  end

  ////////////////////////////////////////
  chk_link_runs: assert property (
    IO_RESET_N |-> link_hold <= 9'h101) else $error("link clock stuck");
  chk_sync_release: assert property (
    $rose(NRST) |-> !RESET_DONE_N [*3] ##[15:30] RESET_DONE_N) else $error("done timing off");
  chk_done_then_io: assert property (
    $rose(RESET_DONE_N) |=> $rose(IO_RESET_N)) else $error("io reset not released");
  chk_leave_idle: assert property (
    $rose(IO_RESET_N) |-> CORE_RESET_N && !CORE_RUN && CORE_IRQ_ENABLE == 4'hF) else $error("core not idle");
  chk_soft_core: assert property (
    WR && ADDR == EMU_CTL_OFS && WDATA[0] && RESET_DONE_N && IO_RESET_N |=> !CORE_RESET_N [*4] ##1 CORE_RESET_N)
    else $error("soft reset pulse wrong");
  chk_soft_io: assert property (
    $fell(CORE_RESET_N) |-> IO_RESET_N [*5]) else $error("io hit by soft reset");
  chk_noload_addr: assert property (
    $rose(CORE_RUN) && BOOT_MODE_STRAPS == BOOT_NONE |-> CORE_START_ADDR == pick($past(EXT_INTERRUPT_LINES_N)))
    else $error("no-load start wrong");
  chk_load_addr: assert property (
    $rose(CORE_RUN) && BOOT_MODE_STRAPS != BOOT_NONE |-> CORE_START_ADDR == 32'h0) else $error("load start wrong");
  chk_ratio_map: assert property (
    RESET_DONE_N |-> CORE_CLOCK_MULT == mult_exp && RATIO_INVALID == (CLOCK_RATIO_STRAPS == 3'h7))
    else $error("ratio map wrong");
  chk_bus_half: assert property (
    IO_RESET_N && $past(IO_RESET_N) |-> ONCHIP_BUS_CLOCK != $past(ONCHIP_BUS_CLOCK)) else $error("bus clock stuck");
endmodule : rbc_checker

bind rbc_top rbc_checker rbc_checker_i (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .CLOCK_RATIO_STRAPS(CLOCK_RATIO_STRAPS), .BOOT_MODE_STRAPS(BOOT_MODE_STRAPS),
  .EXT_INTERRUPT_LINES_N(EXT_INTERRUPT_LINES_N), .RESET_DONE_N(RESET_DONE_N), .CORE_RESET_N(CORE_RESET_N),
  .IO_RESET_N(IO_RESET_N), .CORE_RUN(CORE_RUN), .CORE_START_ADDR(CORE_START_ADDR),
  .CORE_IRQ_ENABLE(CORE_IRQ_ENABLE), .CORE_CLOCK_MULT(CORE_CLOCK_MULT), .RATIO_INVALID(RATIO_INVALID),
  .ONCHIP_BUS_CLOCK(ONCHIP_BUS_CLOCK), .LINK_CLOCK_OUT(LINK_CLOCK_OUT));

/* File: tb/tb_reset_boot_clock_ratio.sv */
// Self-checking bench: reads queue expectations, a monitor compares RDATA.
// Assumes the board model owns NRST and the ratio straps.
`timescale 1ns/1ns
module tb_reset_boot_clock_ratio;
  import rbc_pkg::*;
  logic        clk, nrst, wr, rd, load_done, rst_req, rd_seen, done_n;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [2:0]  straps, ratio_sel;
  logic [1:0]  boot;
  logic [3:0]  irq_n, pat;
  int          miscompares, comparisons, cycles;
  logic [31:0] exp_q[$];
  string       name_q[$];

  rbc_board rbc_board_i (.clk(clk), .rst_req(rst_req), .ratio_sel(ratio_sel), .mem_por_n(done_n),
    .chip_rst_n(nrst), .ratio_straps(straps));
  rbc_top rbc_top_i (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CLOCK_RATIO_STRAPS(straps), .BOOT_MODE_STRAPS(boot), .EXT_INTERRUPT_LINES_N(irq_n),
    .BOOT_LOAD_DONE(load_done), .RESET_DONE_N(done_n), .CORE_RESET_N(), .IO_RESET_N(), .CORE_RUN(),
    .CORE_START_ADDR(), .CORE_IRQ_ENABLE(), .CORE_CLOCK_MULT(), .RATIO_INVALID(), .ONCHIP_BUS_CLOCK(),
    .LINK_CLOCK_OUT());

  ////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, seen);
    end
  endtask : check

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // One bus cycle; a gap edge between calls keeps strobes single
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(n);
    bus(1'b0, a, 32'h0);
  endtask : rd_chk

  // Bounded wait, a hang counts as a miss
  task automatic wait_for(ref logic sig, input logic v);
    for (int i = 0; i < 64 && sig !== v; i++) @(posedge clk);
    check("done wait", {31'h0, sig}, {31'h0, v});
  endtask : wait_for

  function automatic logic [31:0] stat(input logic [2:0] s, input logic [1:0] b, input logic [1:0] st);
    logic [3:0] m;
    m = s == 3'h7 ? 4'h0 : s == 3'h6 ? 4'hC : s == 3'h5 ? 4'hA : {1'b0, s} + 4'h4;
    return {19'h0, 1'b1, b, st, m, s == 3'h7, s};
  endfunction : stat

  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Monitor: RDATA stands only in the cycle after RD
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rd_seen && exp_q.size() > 0)
      check(name_q.pop_front(), rdata, exp_q.pop_front());
    rd_seen <= rd;
    if (cycles == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // Each pass: fresh chip reset, strap code s, boot mode s mod 4
  initial
  begin
    {wr, rd, load_done, rst_req, rd_seen, addr, wdata, ratio_sel, boot} = '0;
    irq_n = 4'hF;
    {miscompares, comparisons, cycles} = '0;
    void'($urandom(32'hF89CDF2B));
    for (int s = 0; s < 8; s++)
    begin
      ratio_sel <= 3'(s);
      boot      <= 2'(s);
      rst_req   <= 1'b1;
      @(posedge clk);
      rst_req <= 1'b0;
      wait_for(done_n, 1'b0);
      wait_for(done_n, 1'b1);
      repeat (3) @(posedge clk);
      pat = 4'($urandom_range(14, 0));
      if (boot == BOOT_NONE) load_done <= 1'b1; else irq_n <= pat;
      @(posedge clk);
      load_done <= 1'b0;
      irq_n     <= 4'hF;
      rd_chk("idle", STATUS_OFS, stat(3'(s), boot, 2'h1));
      if (boot == BOOT_NONE) irq_n <= pat; else load_done <= 1'b1;
      @(posedge clk);
      load_done <= 1'b0;
      irq_n     <= 4'hF;
      rd_chk("start", START_ADDR_OFS, boot != BOOT_NONE ? 32'h0 : !pat[0] ? 32'h3000_0000 :
        !pat[1] ? 32'h3800_0000 : !pat[2] ? 32'h8000_0000 : 32'h0);
      rd_chk("run", STATUS_OFS, stat(3'(s), boot, 2'h3));
    end
    // Soft reset must leave the link divisor and done flag alone
    d = 32'($urandom_range(255, 0));
    bus(1'b1, LINK_DIV_OFS, d);
    bus(1'b1, EMU_CTL_OFS, 32'h1);
    rd_chk("held", STATUS_OFS, stat(3'h7, 2'h3, 2'h0));
    repeat (8) @(posedge clk);
    rd_chk("after soft", STATUS_OFS, stat(3'h7, 2'h3, 2'h1));
    rd_chk("link div", LINK_DIV_OFS, d);
    rd_chk("unmapped", 8'h10, 32'h0);
    rd_chk("soft bit", EMU_CTL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule : tb_reset_boot_clock_ratio
